// >>> design/pmx_pkg.sv
package pmx_pkg;

  // ==========================================================================
  // bus and register map (word indices, byte address = 4 * index)
  // ==========================================================================
  localparam int          PMX_ADR_W      = 16;
  localparam int          PMX_DAT_W      = 32;
  localparam int          PMX_REG_W      = 16;
  localparam logic [13:0] PMX_IDX_EXTERNAL_BUS_SELECTION_REGISTER   = 14'h1c00;
  localparam logic [13:0] PMX_IDX_SLEW   = 14'h1c16;
  localparam logic [13:0] PMX_IDX_PDI1   = 14'h1c17;
  localparam logic [13:0] PMX_IDX_PDI2   = 14'h1c18;
  localparam logic [13:0] PMX_IDX_PDI3   = 14'h1c19;

  // ==========================================================================
  // fields, writable masks, reset values
  // ==========================================================================
  localparam int          PMX_PP_LSB     = 12;
  localparam int          PMX_SP1_LSB    = 10;
  localparam logic [15:0] PMX_EXTERNAL_BUS_SELECTION_REGISTER_MASK  = 16'h7c00;
  localparam logic [15:0] PMX_SLEW_MASK  = 16'h0001;
  localparam logic [15:0] PMX_PDI1_MASK  = 16'hffff;
  localparam logic [15:0] PMX_PDI2_MASK  = 16'hffff;
  localparam logic [15:0] PMX_PDI3_MASK  = 16'hfffc;
  localparam logic [15:0] PMX_EXTERNAL_BUS_SELECTION_REGISTER_RST   = 16'h0000;
  localparam logic [15:0] PMX_SLEW_RST   = 16'h0000;
  localparam logic [15:0] PMX_PDI_RST    = 16'h0000;

  // ==========================================================================
  // mode codes
  // ==========================================================================
  localparam logic [2:0]  PMX_PP_M0      = 3'h0;
  localparam logic [2:0]  PMX_PP_M1      = 3'h1;
  localparam logic [2:0]  PMX_PP_M2      = 3'h2;
  localparam logic [2:0]  PMX_PP_M3      = 3'h3;
  localparam logic [2:0]  PMX_PP_M4      = 3'h4;
  localparam logic [2:0]  PMX_PP_M5      = 3'h5;
  localparam logic [2:0]  PMX_PP_M6      = 3'h6;
  localparam logic [1:0]  PMX_SP1_M0     = 2'h0;
  localparam logic [1:0]  PMX_SP1_M1     = 2'h1;
  localparam logic [1:0]  PMX_SP1_M2     = 2'h2;

  // ==========================================================================
  // pins and peripheral function pool
  // ==========================================================================
  localparam int          PMX_PP_PINS    = 21;
  localparam int          PMX_PINS       = 27;
  localparam int          PMX_FN         = 82;
  localparam logic [6:0]  PMX_FN_LCD     = 7'h00;
  localparam logic [6:0]  PMX_FN_SPI     = 7'h15;
  localparam logic [6:0]  PMX_FN_UART    = 7'h1c;
  localparam logic [6:0]  PMX_FN_AU2     = 7'h20;
  localparam logic [6:0]  PMX_FN_AU3     = 7'h24;
  localparam logic [6:0]  PMX_FN_AU1     = 7'h28;
  localparam logic [6:0]  PMX_FN_SD1     = 7'h2c;
  localparam logic [6:0]  PMX_FN_GP      = 7'h32;
  localparam logic [6:0]  PMX_FN_NONE    = 7'h7f;

endpackage

// >>> design/pmx_route.sv
`timescale 1ns/10ps
`default_nettype none

module pmx_route (
  pmx_route_if.mux rt
);

  // ==========================================================================
  // per-pin source decode
  // ==========================================================================
  function automatic logic [6:0] pin_src(input logic [2:0] pp,
                                         input logic [1:0] sp,
                                         input logic [4:0] p);
    logic [6:0] r;
    logic [4:0] e;
    logic [4:0] q;
    r = pmx_pkg::PMX_FN_NONE;
    e = p - 5'd13;
    q = p - 5'd21;
    if (p >= 5'd21) begin
      case (sp)
        // R9: sd card routing
        pmx_pkg::PMX_SP1_M0: r = pmx_pkg::PMX_FN_SD1 + 7'(q);
        // R10: audio 1 plus gpio
        pmx_pkg::PMX_SP1_M1: begin
          if (q < 5'd4) begin
            r = pmx_pkg::PMX_FN_AU1 + 7'(q ^ {4'd0, q[1]});
          end else begin
            r = pmx_pkg::PMX_FN_GP + 7'd6 + 7'(q);
          end
        end
        // R11: gpio 6 to 11
        pmx_pkg::PMX_SP1_M2: r = pmx_pkg::PMX_FN_GP + 7'd6 + 7'(q);
        // R20: reserved leaves pin free
        default: r = pmx_pkg::PMX_FN_NONE;
      endcase
    end else begin
      case (pp)
        // R4: full lcd routing
        pmx_pkg::PMX_PP_M0: r = pmx_pkg::PMX_FN_LCD + 7'(p);
        // R5 R6: spi, gpio, audio 2, uart or audio 3
        pmx_pkg::PMX_PP_M1, pmx_pkg::PMX_PP_M6: begin
          if (p < 5'd7) begin
            r = pmx_pkg::PMX_FN_SPI + 7'(p);
          end else if (p < 5'd13) begin
            r = pmx_pkg::PMX_FN_GP + 7'd5 + 7'(p);
          end else if (p < 5'd17) begin
            r = pmx_pkg::PMX_FN_AU2 + 7'(e);
          end else if (pp == pmx_pkg::PMX_PP_M1) begin
            r = pmx_pkg::PMX_FN_UART + 7'(e) - 7'd4;
          end else begin
            r = pmx_pkg::PMX_FN_AU3 + 7'(e) - 7'd4;
          end
        end
        pmx_pkg::PMX_PP_M2, pmx_pkg::PMX_PP_M3,
        pmx_pkg::PMX_PP_M4, pmx_pkg::PMX_PP_M5: begin
          if (p < 5'd13) begin
            // R4: control and low data stay lcd
            r = pmx_pkg::PMX_FN_LCD + 7'(p);
          end else if (pp == pmx_pkg::PMX_PP_M2) begin
            // R7: gpio 18-20, 27-31
            r = pmx_pkg::PMX_FN_GP + 7'(e) + ((e < 5'd3) ? 7'd18 : 7'd24);
          end else if (e < 5'd4) begin
            // R8: spi or audio 2 on data 8-11
            if (pp == pmx_pkg::PMX_PP_M4) begin
              r = pmx_pkg::PMX_FN_AU2 + 7'(e);
            end else begin
              r = pmx_pkg::PMX_FN_SPI + 7'(e) + ((e < 5'd2) ? 7'd0 : 7'd3);
            end
          end else if (pp == pmx_pkg::PMX_PP_M3) begin
            // R8: audio 3 on data 12-15
            r = pmx_pkg::PMX_FN_AU3 + 7'(e) - 7'd4;
          end else begin
            r = pmx_pkg::PMX_FN_UART + 7'(e) - 7'd4;
          end
        end
        // R20: reserved leaves pin free
        default: r = pmx_pkg::PMX_FN_NONE;
      endcase
    end
    return r;
  endfunction

  // ==========================================================================
  // pin drive
  // ==========================================================================
  logic [6:0] src_w [pmx_pkg::PMX_PINS];

  genvar gi;
  generate
    for (gi = 0; gi < pmx_pkg::PMX_PINS; gi++) begin : g_pin
      // R1: routing from selection fields only
      assign src_w[gi]      = pin_src(rt.pp_mode, rt.sp1_mode, 5'(gi));
      assign rt.pad_out[gi] = (src_w[gi] != pmx_pkg::PMX_FN_NONE) &&
                              rt.fn_out[src_w[gi]];
      assign rt.pad_oe[gi]  = (src_w[gi] != pmx_pkg::PMX_FN_NONE) &&
                              rt.fn_oe[src_w[gi]];
    end
  endgenerate

  // ==========================================================================
  // pin sample back to peripherals
  // ==========================================================================
  always_comb begin
    rt.fn_in = '0;
    for (int k = 0; k < pmx_pkg::PMX_PINS; k++) begin
      if (src_w[k] != pmx_pkg::PMX_FN_NONE) begin
        rt.fn_in[src_w[k]] = rt.pad_in[k];
      end
    end
  end

endmodule // pmx_route

`default_nettype wire

// >>> design/pmx_route_if.sv
`timescale 1ns/10ps
`default_nettype none

interface pmx_route_if;
  logic [2:0]                    pp_mode;
  logic [1:0]                    sp1_mode;
  logic [pmx_pkg::PMX_PINS-1:0]  pad_in;
  logic [pmx_pkg::PMX_PINS-1:0]  pad_out;
  logic [pmx_pkg::PMX_PINS-1:0]  pad_oe;
  logic [pmx_pkg::PMX_FN-1:0]    fn_out;
  logic [pmx_pkg::PMX_FN-1:0]    fn_oe;
  logic [pmx_pkg::PMX_FN-1:0]    fn_in;

  modport mux (input pp_mode, sp1_mode, pad_in, fn_out, fn_oe,
               output pad_out, pad_oe, fn_in);
  modport ctl (output pp_mode, sp1_mode, pad_in, fn_out, fn_oe,
               input pad_out, pad_oe, fn_in);
endinterface // pmx_route_if

`default_nettype wire

// >>> design/pmx_top.sv
// What this block does
// R1: Pin routing comes only from the external bus selection register fields.
// R2: Software resets affected peripherals after changing any routing field.
// R3: Three-bit parallel mode field selects seven routings, codes 0 to 6.
// R4: Mode 0 all lcd; modes 2-5 keep lcd control and data 0-7.
// R5: Mode 1 gives spi, gpio 12-17, audio 2 and uart pins.
// R6: Mode 6 equals mode 1 but data 12-15 carry audio 3.
// R7: Mode 2 routes data 8-15 to gpio 18-20 and 27-31.
// R8: Modes 3-5 route data 8-15 to spi, audio 2/3, uart.
// R9: Serial port 1 code 0 routes six pins to sd card 1.
// R10: Code 1 gives audio 1 on four pins, gpio 10-11 on two.
// R11: Code 2 routes the six pins to gpio 6 through 11.
// R12: Third inhibit register controls pulldowns of lcd data 2-15 only.
// R13: First inhibit register controls pulldowns of the six serial pins.
// R14: Every pull is controllable via three inhibit registers, except test reset.
// R15: Software disables internal pulls when external pull or driver exists.
// R16: Core power off forces all pulls off and enables bus holders.
// R17: Slew register picks fast or slow slew for clock output only.
// R18: Parallel mode field sits in bits 14 to 12.
// R19: Serial port 1 field sits in bits 11 to 10; code 3 reserved.
// R20: Reserved codes leave affected pins undriven and disconnected.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

module pmx_top (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  input  wire logic [pmx_pkg::PMX_ADR_W-1:0] wb_adr_i,
  input  wire logic [pmx_pkg::PMX_DAT_W-1:0] wb_dat_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic                         wb_we_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  output logic      [pmx_pkg::PMX_DAT_W-1:0] wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic                         core_pwr_on_i,
  input  wire logic [pmx_pkg::PMX_FN-1:0]   fn_out_i,
  input  wire logic [pmx_pkg::PMX_FN-1:0]   fn_oe_i,
  output logic      [pmx_pkg::PMX_FN-1:0]   fn_in_o,
  input  wire logic [pmx_pkg::PMX_PINS-1:0] pad_i,
  output logic      [pmx_pkg::PMX_PINS-1:0] pad_o,
  output logic      [pmx_pkg::PMX_PINS-1:0] pad_oe_o,
  output logic      [15:0]                  pull_en1_o,
  output logic      [15:0]                  pull_en2_o,
  output logic      [15:0]                  pull_en3_o,
  output logic                              bus_hold_en_o,
  output logic                              clock_output_pin_slow_o
);

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [15:0] lane_wr(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel,
                                          input logic [15:0] mask);
    logic [15:0] r;
    r = old_v;
    if (sel[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (sel[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r & mask;
  endfunction

  // ==========================================================================
  // register state
  // ==========================================================================
  logic [15:0] external_bus_selection_register_q;
  logic [15:0] external_bus_selection_register_d;
  logic [15:0] slew_q;
  logic [15:0] slew_d;
  logic [15:0] pdi1_q;
  logic [15:0] pdi1_d;
  logic [15:0] pdi2_q;
  logic [15:0] pdi2_d;
  logic [15:0] pdi3_q;
  logic [15:0] pdi3_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic        req_w;
  logic        word_w;
  logic [13:0] idx_w;

  assign req_w  = wb_cyc_i && wb_stb_i && !ack_q;
  assign word_w = (wb_adr_i[1:0] == 2'b00);
  assign idx_w  = wb_adr_i[15:2];

  always_comb begin
    external_bus_selection_register_d = external_bus_selection_register_q;
    slew_d = slew_q;
    pdi1_d = pdi1_q;
    pdi2_d = pdi2_q;
    pdi3_d = pdi3_q;
    ack_d  = req_w;
    rdat_d = 32'h0000_0000;
    if (req_w && word_w) begin
      case (idx_w)
        pmx_pkg::PMX_IDX_EXTERNAL_BUS_SELECTION_REGISTER: begin
          // R18 R19: mode fields in bits 14:10
          if (wb_we_i) begin
            external_bus_selection_register_d = lane_wr(external_bus_selection_register_q, wb_dat_i, wb_sel_i, pmx_pkg::PMX_EXTERNAL_BUS_SELECTION_REGISTER_MASK);
          end
          rdat_d = {16'h0000, external_bus_selection_register_q};
        end
        pmx_pkg::PMX_IDX_SLEW: begin
          // R17: clock output slew select
          if (wb_we_i) begin
            slew_d = lane_wr(slew_q, wb_dat_i, wb_sel_i, pmx_pkg::PMX_SLEW_MASK);
          end
          rdat_d = {16'h0000, slew_q};
        end
        pmx_pkg::PMX_IDX_PDI1: begin
          // R13: serial pin pulldown inhibits
          if (wb_we_i) begin
            pdi1_d = lane_wr(pdi1_q, wb_dat_i, wb_sel_i, pmx_pkg::PMX_PDI1_MASK);
          end
          rdat_d = {16'h0000, pdi1_q};
        end
        pmx_pkg::PMX_IDX_PDI2: begin
          // R14: remaining pull inhibits
          if (wb_we_i) begin
            pdi2_d = lane_wr(pdi2_q, wb_dat_i, wb_sel_i, pmx_pkg::PMX_PDI2_MASK);
          end
          rdat_d = {16'h0000, pdi2_q};
        end
        pmx_pkg::PMX_IDX_PDI3: begin
          // R12: lcd data 2-15 inhibits
          if (wb_we_i) begin
            pdi3_d = lane_wr(pdi3_q, wb_dat_i, wb_sel_i, pmx_pkg::PMX_PDI3_MASK);
          end
          rdat_d = {16'h0000, pdi3_q};
        end
        default: rdat_d = 32'h0000_0000;
      endcase
      // write acks carry no data
      if (wb_we_i) begin
        rdat_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      external_bus_selection_register_q <= pmx_pkg::PMX_EXTERNAL_BUS_SELECTION_REGISTER_RST;
      slew_q <= pmx_pkg::PMX_SLEW_RST;
      pdi1_q <= pmx_pkg::PMX_PDI_RST;
      pdi2_q <= pmx_pkg::PMX_PDI_RST;
      pdi3_q <= pmx_pkg::PMX_PDI_RST;
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      external_bus_selection_register_q <= external_bus_selection_register_d;
      slew_q <= slew_d;
      pdi1_q <= pdi1_d;
      pdi2_q <= pdi2_d;
      pdi3_q <= pdi3_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ==========================================================================
  // routing core
  // ==========================================================================
  pmx_route_if rt ();

  // R1 R3: modes taken from the selection register
  assign rt.pp_mode  = external_bus_selection_register_q[pmx_pkg::PMX_PP_LSB +: 3];
  assign rt.sp1_mode = external_bus_selection_register_q[pmx_pkg::PMX_SP1_LSB +: 2];
  assign rt.pad_in   = pad_i;
  assign rt.fn_out   = fn_out_i;
  assign rt.fn_oe    = fn_oe_i;

  pmx_route u_route (
    .rt (rt.mux)
  );

  // ==========================================================================
  // pad state
  // ==========================================================================
  logic [pmx_pkg::PMX_PINS-1:0] pad_q;
  logic [pmx_pkg::PMX_PINS-1:0] pad_d;
  logic [pmx_pkg::PMX_PINS-1:0] oe_q;
  logic [pmx_pkg::PMX_PINS-1:0] oe_d;
  logic [pmx_pkg::PMX_FN-1:0]   fin_q;
  logic [pmx_pkg::PMX_FN-1:0]   fin_d;
  logic [15:0]                  pu1_q;
  logic [15:0]                  pu1_d;
  logic [15:0]                  pu2_q;
  logic [15:0]                  pu2_d;
  logic [15:0]                  pu3_q;
  logic [15:0]                  pu3_d;
  logic                         hold_q;
  logic                         hold_d;
  logic                         slow_q;
  logic                         slow_d;

  always_comb begin
    pad_d  = rt.pad_out;
    oe_d   = rt.pad_oe;
    fin_d  = rt.fn_in;
    // R16: pulls forced off without core power
    pu1_d  = core_pwr_on_i ? ~pdi1_q & pmx_pkg::PMX_PDI1_MASK : 16'h0000;
    pu2_d  = core_pwr_on_i ? ~pdi2_q & pmx_pkg::PMX_PDI2_MASK : 16'h0000;
    pu3_d  = core_pwr_on_i ? ~pdi3_q & pmx_pkg::PMX_PDI3_MASK : 16'h0000;
    // R16: bus holders instead
    hold_d = !core_pwr_on_i;
    // R17: slew affects only the clock output
    slow_d = slew_q[0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_q  <= '0;
      oe_q   <= '0;
      fin_q  <= '0;
      pu1_q  <= 16'h0000;
      pu2_q  <= 16'h0000;
      pu3_q  <= 16'h0000;
      hold_q <= 1'b0;
      slow_q <= 1'b0;
    end else if (ce_i) begin
      pad_q  <= pad_d;
      oe_q   <= oe_d;
      fin_q  <= fin_d;
      pu1_q  <= pu1_d;
      pu2_q  <= pu2_d;
      pu3_q  <= pu3_d;
      hold_q <= hold_d;
      slow_q <= slow_d;
    end
  end

  assign pad_o         = pad_q;
  assign pad_oe_o      = oe_q;
  assign fn_in_o       = fin_q;
  assign pull_en1_o    = pu1_q;
  assign pull_en2_o    = pu2_q;
  assign pull_en3_o    = pu3_q;
  assign bus_hold_en_o = hold_q;
  assign clock_output_pin_slow_o = slow_q;

endmodule // pmx_top

`default_nettype wire

// >>> test/parallel_serial_pin_mux_test.sv
`timescale 1ns/10ps
`default_nettype none

module parallel_serial_pin_mux_test;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, pwr = 1'b1, hold = 1'b0, prst = 1'b0;
  logic        we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, bh, slow;
  logic [15:0] adr = 16'h0, pe1, pe2, pe3;
  logic [31:0] dat = 32'h0, dato, rd;
  logic [3:0]  sel = 4'h0;
  logic [81:0] fo, fe, fi;
  logic [26:0] pin, po, poe;
  int          errors = 0, cmp_count = 0;
  logic [13:0] ra [5] = '{pmx_pkg::PMX_IDX_EXTERNAL_BUS_SELECTION_REGISTER, pmx_pkg::PMX_IDX_SLEW,
                          pmx_pkg::PMX_IDX_PDI1, pmx_pkg::PMX_IDX_PDI2, pmx_pkg::PMX_IDX_PDI3};
  logic [15:0] rm [5] = '{16'h7c00, 16'h0001, 16'hffff, 16'hffff, 16'hfffc};

  pmx_top dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dato),
    .wb_ack_o(ack), .core_pwr_on_i(pwr), .fn_out_i(fo), .fn_oe_i(fe), .fn_in_o(fi),
    .pad_i(pin), .pad_o(po), .pad_oe_o(poe), .pull_en1_o(pe1), .pull_en2_o(pe2),
    .pull_en3_o(pe3), .bus_hold_en_o(bh), .clock_output_pin_slow_o(slow));
  pmx_periph_model peri (.clk_i(clk), .rst_i(rst || prst), .hold_i(hold), .fn_out_o(fo),
    .fn_oe_o(fe), .pin_o(pin));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // compare, verdict, bus access
  // ==========================================================================
  task automatic chk(input string s, input logic [81:0] e, input logic [81:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [13:0] i, input logic [1:0] lo,
                    input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, lo};
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = dato;
    if (k >= 20) begin
      errors++;
      conclude();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // pool index carried by pin p, -1 when unrouted
  function automatic int fsel(input int m, input int s, input int p);
    if (p > 20) begin
      if (s == 0) return 23 + p;
      if (s == 2) return 35 + p;
      if (s == 3) return -1;
      return (p < 23) ? 19 + p : (p == 23) ? 43 : (p == 24) ? 42 : 35 + p;
    end
    if (m == 7) return -1;
    if (m == 0 || (m != 1 && m != 6 && p < 13)) return p;
    if (m == 1 || m == 6) begin
      if (p < 7) return 21 + p;
      if (p < 13) return 55 + p;
      if (p < 17) return 19 + p;
      return (m == 1) ? 11 + p : 19 + p;
    end
    if (p < 17) return (m == 2) ? ((p < 16) ? 55 + p : 77) : (m == 4) ? 19 + p :
                       (p < 15) ? 8 + p : 11 + p;
    return (m == 2) ? 61 + p : (m == 3) ? 19 + p : 11 + p;
  endfunction

  task automatic route(input int m, input int s);
    logic [81:0] ei;
    logic [26:0] eo, ee;
    int f;
    ei = 82'h0;
    eo = 27'h0;
    ee = 27'h0;
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    for (int p = 0; p < 27; p++) begin
      f = fsel(m, s, p);
      if (f >= 0) begin
        eo[p] = fo[f];
        ee[p] = fe[f];
        ei[f] = pin[p];
      end
    end
    chk("pad_o", eo, po);
    chk("pad_oe_o", ee, poe);
    chk("fn_in_o", ei, fi);
    hold <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end

  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, ra[i], 2'h0, 32'h0, 4'hf);
      chk("reset reg", 32'h0, rd);
    end
    chk("pull_en", {16'hffff, 16'hffff, 16'hfffc}, {pe1, pe2, pe3});
    chk("hold slow", 2'h0, {bh, slow});
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, ra[i], 2'h0, 32'hffffffff, 4'hf);
      wb(1'b0, ra[i], 2'h0, 32'h0, 4'hf);
      chk("masked reg", {16'h0, rm[i]}, rd);
    end
    chk("pulls inhibited", 48'h0, {pe1, pe2, pe3});
    chk("clock_output_pin_slow", 1'b1, slow);
    route(7, 3);
    $display("test masks done");
    wb(1'b1, 14'h1c01, 2'h0, 32'h0, 4'hf);
    wb(1'b0, 14'h1c01, 2'h0, 32'h0, 4'hf);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, pmx_pkg::PMX_IDX_EXTERNAL_BUS_SELECTION_REGISTER, 2'h2, 32'h0, 4'hf);
    wb(1'b1, pmx_pkg::PMX_IDX_EXTERNAL_BUS_SELECTION_REGISTER, 2'h0, 32'h0, 4'h1);
    wb(1'b0, pmx_pkg::PMX_IDX_EXTERNAL_BUS_SELECTION_REGISTER, 2'h0, 32'h0, 4'hf);
    chk("external_bus_selection_register kept", 32'h7c00, rd);
    $display("test decode done");
    for (int m = 0; m < 7; m++) begin
      wb(1'b1, pmx_pkg::PMX_IDX_EXTERNAL_BUS_SELECTION_REGISTER, 2'h0, {17'h0, m[2:0], 2'(m % 3), 10'h0}, 4'h3);
      prst <= 1'b1;
      @(posedge clk);
      prst <= 1'b0;
      route(m, m % 3);
    end
    $display("test routing done");
    wb(1'b1, pmx_pkg::PMX_IDX_PDI1, 2'h0, 32'ha5a5, 4'h3);
    wb(1'b1, pmx_pkg::PMX_IDX_PDI2, 2'h0, 32'h5a5a, 4'h3);
    wb(1'b1, pmx_pkg::PMX_IDX_PDI3, 2'h0, 32'h00f0, 4'h3);
    wb(1'b1, pmx_pkg::PMX_IDX_SLEW, 2'h0, 32'h0, 4'h3);
    chk("pull_en", {16'h5a5a, 16'ha5a5, 16'hff0c, 1'b0}, {pe1, pe2, pe3, slow});
    pwr <= 1'b0;
    repeat (2) @(posedge clk);
    chk("power off", {48'h0, 1'b1}, {pe1, pe2, pe3, bh});
    pwr <= 1'b1;
    repeat (2) @(posedge clk);
    chk("power on", {16'hff0c, 1'b0}, {pe3, bh});
    $display("test pulls done");
    conclude();
  end
endmodule // parallel_serial_pin_mux_test

`default_nettype wire

// >>> test/pmx_periph_model.sv
`timescale 1ns/10ps
`default_nettype none

module pmx_periph_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hold_i,
  output logic      [81:0] fn_out_o,
  output logic      [81:0] fn_oe_o,
  output logic      [26:0] pin_o
);
  // ==========================================================================
  // peripheral and pin traffic, changing every cycle unless held
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fn_out_o <= 82'h0c3c3c3c3c3c3c3c3c3c3;
      fn_oe_o  <= 82'h2aaaaaaaaaaaaaaaaaaaa;
      pin_o    <= 27'h5a5a5a5;
    end else if (!hold_i) begin
      fn_out_o <= {fn_out_o[80:0], ~fn_out_o[81]};
      fn_oe_o  <= {fn_oe_o[0], fn_oe_o[81:1]};
      pin_o    <= {pin_o[25:0], ~pin_o[26]};
    end
  end
endmodule // pmx_periph_model

`default_nettype wire

// >>> test/pmx_top_checker.sv
`timescale 1ns/10ps
`default_nettype none

module pmx_top_checker (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         ce_i,
  input wire logic [pmx_pkg::PMX_ADR_W-1:0] wb_adr_i,
  input wire logic [pmx_pkg::PMX_DAT_W-1:0] wb_dat_i,
  input wire logic [3:0]                   wb_sel_i,
  input wire logic                         wb_we_i,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic [pmx_pkg::PMX_DAT_W-1:0] wb_dat_o,
  input wire logic                         wb_ack_o,
  input wire logic                         core_pwr_on_i,
  input wire logic [pmx_pkg::PMX_FN-1:0]   fn_out_i,
  input wire logic [pmx_pkg::PMX_FN-1:0]   fn_oe_i,
  input wire logic [pmx_pkg::PMX_PINS-1:0] pad_o,
  input wire logic [pmx_pkg::PMX_PINS-1:0] pad_oe_o,
  input wire logic [15:0]                  pull_en1_o,
  input wire logic [15:0]                  pull_en2_o,
  input wire logic [15:0]                  pull_en3_o,
  input wire logic                         bus_hold_en_o
);
  logic [2:0]  pp_q, pp_d, pv_q;
  logic [1:0]  sp_q, sp_d, sv_q;
  logic        v_q;
  logic [81:0] fo_q, fe_q;

  // ==========================================================================
  // mirror of the routing fields, delayed copies of inputs
  // ==========================================================================
  always_comb begin
    pp_d = pp_q;
    sp_d = sp_q;
    if (rst_i) begin
      pp_d = 3'h0;
      sp_d = 2'h0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i && wb_sel_i[1]
                 && wb_adr_i == {pmx_pkg::PMX_IDX_EXTERNAL_BUS_SELECTION_REGISTER, 2'h0}) begin
      pp_d = wb_dat_i[14:12];
      sp_d = wb_dat_i[11:10];
    end
  end

  always_ff @(posedge clk_i) begin
    pp_q <= pp_d;
    sp_q <= sp_d;
    pv_q <= pp_q;
    sv_q <= sp_q;
    v_q  <= ce_i && !rst_i;
    fo_q <= fn_out_i;
    fe_q <= fn_oe_i;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // assertions
  // ==========================================================================
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("request not acked next cycle");
  ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  rdata_idle_a: assert property (!(wb_ack_o && !wb_we_i) |-> wb_dat_o == 32'h0)
    else $error("read data outside read ack");
  hold_power_a: assert property (
    $past(ce_i) && !$past(rst_i) |-> bus_hold_en_o == !$past(core_pwr_on_i))
    else $error("bus holder not tied to core power");
  pull_off_a: assert property (
    $past(ce_i) && !$past(rst_i) && !$past(core_pwr_on_i)
      |-> {pull_en1_o, pull_en2_o, pull_en3_o} == 48'h0)
    else $error("pull enabled with core off");
  pdi3_fixed_a: assert property (pull_en3_o[1:0] == 2'h0)
    else $error("pull on lcd data 0 or 1");
  lcd_mode0_a: assert property (v_q && pv_q == 3'h0
    |-> pad_o[20:0] == fo_q[20:0] && pad_oe_o[20:0] == fe_q[20:0])
    else $error("mode 0 pins not lcd");
  spi_mode1_a: assert property (v_q && pv_q == 3'h1
    |-> pad_o[6:0] == fo_q[27:21] && pad_o[20:13] == {fo_q[31:28], fo_q[35:32]})
    else $error("mode 1 pins misrouted");
  sd_mode0_a: assert property (v_q && sv_q == 2'h0 |-> pad_o[26:21] == fo_q[49:44])
    else $error("serial mode 0 pins not sd");
  sp1_rsvd_a: assert property (v_q && sv_q == 2'h3
    |-> pad_oe_o[26:21] == 6'h0 && pad_o[26:21] == 6'h0)
    else $error("reserved serial mode drives pins");
endmodule // pmx_top_checker

bind pmx_top pmx_top_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_pwr_on_i(core_pwr_on_i),
  .fn_out_i(fn_out_i), .fn_oe_i(fn_oe_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o),
  .pull_en1_o(pull_en1_o), .pull_en2_o(pull_en2_o), .pull_en3_o(pull_en3_o),
  .bus_hold_en_o(bus_hold_en_o)
);

`default_nettype wire
